// ==== shared/tcp_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Constants, register map and types of the timer/counter/PWM block.
// Assumes: 16-bit register port, word indexed, one clock domain.
// Notes:   Shared by the timer core and its prescaler.
//////////////////////////////////////////////////////////////////////////////
package tcp_pkg;

   localparam int DATA_W = 16;
   localparam int ADDR_W = 3;
   localparam int PRESC_SEL_W = 3;
   localparam int PRESC_CNT_W = 7;

   // Register indices on the register port.
   localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
   localparam logic [ADDR_W-1:0] REG_COUNT = 3'h1;
   localparam logic [ADDR_W-1:0] REG_RELOAD = 3'h2;
   localparam logic [ADDR_W-1:0] REG_MATCH = 3'h3;
   localparam logic [ADDR_W-1:0] REG_STATUS = 3'h4;

   // Values after reset and special counts.
   localparam logic [DATA_W-1:0] COUNT_RST = 16'h0001;
   localparam logic [DATA_W-1:0] COUNT_RESTART = 16'h0001;
   localparam logic [DATA_W-1:0] COUNT_ALL_ONES = 16'hffff;
   localparam logic [DATA_W-1:0] RELOAD_RST = 16'h0000;
   localparam logic [DATA_W-1:0] MATCH_RST = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
   localparam logic [PRESC_CNT_W-1:0] PRESC_CNT_RST = 7'h00;

   // Operating modes held in the control register.
   localparam logic [1:0] MODE_COUNTER = 2'h0;
   localparam logic [1:0] MODE_PWM = 2'h1;
   localparam logic [1:0] MODE_CAPTURE = 2'h2;

   // Control register layout, bit 7 down to bit 0.
   typedef struct packed {
      logic enable;
      logic out_en;
      logic output_polarity_select;
      logic [1:0] mode;
      logic [PRESC_SEL_W-1:0] prescale;
   } tcp_ctrl_t;

   localparam int CTRL_W = 8;
   localparam tcp_ctrl_t CTRL_RST = 8'h00;

endpackage

// ==== verilog/tcp_prescaler.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: Power-of-two prescaler giving one tick per 1 to 128 clocks.
// Assumes: Select value n divides by two to the power n.
// Notes:   The divider restarts whenever it is not enabled.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module tcp_prescaler
   import tcp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic enable_i,
   input wire logic [PRESC_SEL_W-1:0] sel_i,
   output logic tick_o
);

   logic [PRESC_CNT_W-1:0] div_cnt;
   logic [PRESC_CNT_W-1:0] next_div_cnt;
   logic [PRESC_CNT_W-1:0] mask;

   always_comb begin
      mask = PRESC_CNT_W'((8'h01 << sel_i) - 8'h01);
      tick_o = enable_i && ((div_cnt & mask) == mask);
      if (!enable_i) begin
         next_div_cnt = PRESC_CNT_RST;
      end else begin
         next_div_cnt = div_cnt + 7'h01;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         div_cnt <= PRESC_CNT_RST;
      end else begin
         div_cnt <= next_div_cnt;
      end
   end

endmodule
`default_nettype wire

// ==== verilog/tcp_timer.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose: 16-bit timer with Counter, PWM and Capture modes.
// Assumes: Timer input is synchronous to core_clk_i; registers on a plain port.
// Notes:   Read data appear in the cycle after the read strobe only.
//
// Functional notes
// [RULE_01] Count is 16 bits, wraps from all ones to zero and keeps counting.
// [RULE_02] Prescale divides the count clock by 1 up to 128.
// [RULE_03] Counter mode counts the selected rising or falling timer input edge.
// [RULE_04] Counter mode edge selection also sets the initial timer output level.
// [RULE_05] Counter mode start count applies once; after reload counting restarts at one.
// [RULE_06] Input transitions seen equal current count minus start count.
// [RULE_07] Software selects edge, start, reload, interrupt, pins, then enables.
// [RULE_08] PWM mode counts prescaled clocks and toggles output at the match value.
// [RULE_09] PWM reload requests an interrupt, sets count to one, keeps counting.
// [RULE_10] Polarity one: output starts high, low at match, high at reload.
// [RULE_11] Polarity zero: output starts low, high at match, low at reload.
// [RULE_12] PWM start count affects only the first period; later ones start at one.
// [RULE_13] Software keeps reload strictly above the match value.
// [RULE_14] Software disables, configures, writes start, match, reload, then enables.
// [RULE_15] PWM period equals reload times prescale over the clock frequency.
// [RULE_16] A start count other than one makes the first period start to reload.
// [RULE_17] Polarity zero high fraction is reload minus match over reload.
// [RULE_18] Polarity one high fraction is match over reload.
// [RULE_19] Capture mode copies the count into the match register on the input edge.
// [RULE_20] Capture mode polarity selects rising or falling capture edge.
// [RULE_21] Counter mode reload requests an interrupt and toggles an enabled output.
// [RULE_22] Every capture requests an interrupt.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module tcp_timer
   import tcp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   input wire logic tin_i,
   output logic tout_o,
   output logic tout_oe_o,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // State.

   tcp_ctrl_t ctrl;
   tcp_ctrl_t next_ctrl;
   logic [DATA_W-1:0] count;
   logic [DATA_W-1:0] next_count;
   logic [DATA_W-1:0] reload;
   logic [DATA_W-1:0] next_reload;
   logic [DATA_W-1:0] match;
   logic [DATA_W-1:0] next_match;
   logic [DATA_W-1:0] next_rdata;
   logic next_tout;
   logic next_irq;
   logic tin_q;

   logic presc_tick;
   logic in_rise;
   logic in_fall;
   logic sel_edge;
   logic tick;
   logic at_reload;
   logic [DATA_W-1:0] count_inc;
   logic wr_count;

   ////////////////////////////////////////////////////////////////////////////
   // Count clock sources.

   // The prescaler runs only in the clock-counting modes.
   tcp_prescaler u_presc (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .enable_i(ctrl.enable && (ctrl.mode != MODE_COUNTER)),
      .sel_i(ctrl.prescale),
      .tick_o(presc_tick)
   );

   always_comb begin
      in_rise = tin_i && !tin_q;
      in_fall = !tin_i && tin_q;
      // Polarity zero selects the rising edge, one the falling edge.
      sel_edge = ctrl.output_polarity_select ? in_fall : in_rise; // [RULE_03] [RULE_20]
      if (ctrl.mode == MODE_COUNTER) begin
         tick = ctrl.enable && sel_edge; // [RULE_03]
      end else begin
         tick = presc_tick; // [RULE_02] [RULE_08] [RULE_19]
      end
      at_reload = (count == reload);
      count_inc = count + 16'h0001; // [RULE_01]
      wr_count = reg_wr_i && (reg_addr_i == REG_COUNT);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   always_comb begin
      next_ctrl = ctrl;
      next_count = count;
      next_reload = reload;
      next_match = match;
      next_tout = tout_o;
      next_irq = 1'b0;
      next_rdata = DATA_ZERO;

      if (!ctrl.enable) begin
         // Idle output holds the polarity level as the starting level.
         next_tout = ctrl.output_polarity_select; // [RULE_04] [RULE_10] [RULE_11]
      end else if (tick) begin
         if (at_reload) begin
            next_count = COUNT_RESTART; // [RULE_05] [RULE_09] [RULE_12] [RULE_16]
            next_irq = 1'b1; // [RULE_09] [RULE_21]
            if (ctrl.mode == MODE_PWM) begin
               next_tout = ctrl.output_polarity_select; // [RULE_10] [RULE_11] [RULE_15]
            end else if (ctrl.mode == MODE_COUNTER && ctrl.out_en) begin
               next_tout = !tout_o; // [RULE_21]
            end
         end else begin
            next_count = count_inc; // [RULE_01] [RULE_06]
            // The output flips on the tick that leaves the match count, so polarity zero
            // is high for reload minus match counts and polarity one for match counts.
            if (ctrl.mode == MODE_PWM && count == match) begin
               next_tout = !ctrl.output_polarity_select; // [RULE_08] [RULE_17] [RULE_18]
            end
         end
      end

      // Register writes; the count written is the start value for one pass.
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            REG_CTRL: next_ctrl = tcp_ctrl_t'(reg_wdata_i[CTRL_W-1:0]);
            REG_COUNT: next_count = reg_wdata_i; // [RULE_05] [RULE_12]
            REG_RELOAD: next_reload = reg_wdata_i;
            REG_MATCH: next_match = reg_wdata_i;
            default: next_ctrl = ctrl;
         endcase
      end

      // A capture beats a simultaneous software write of the match register.
      if (ctrl.enable && ctrl.mode == MODE_CAPTURE && sel_edge) begin
         next_match = count; // [RULE_19] [RULE_20]
         next_irq = 1'b1; // [RULE_22]
      end

      if (reg_rd_i) begin
         unique case (reg_addr_i)
            REG_CTRL: next_rdata = {{(DATA_W-CTRL_W){1'b0}}, ctrl};
            REG_COUNT: next_rdata = count;
            REG_RELOAD: next_rdata = reload;
            REG_MATCH: next_rdata = match;
            REG_STATUS: next_rdata = {14'h0000, tout_o, ctrl.enable};
            default: next_rdata = DATA_ZERO;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         ctrl <= CTRL_RST;
         count <= COUNT_RST;
         reload <= RELOAD_RST;
         match <= MATCH_RST;
         tout_o <= 1'b0;
         tout_oe_o <= 1'b0;
         irq_o <= 1'b0;
         reg_rdata_o <= DATA_ZERO;
         tin_q <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         count <= next_count;
         reload <= next_reload;
         match <= next_match;
         tout_o <= next_tout;
         tout_oe_o <= next_ctrl.out_en;
         irq_o <= next_irq;
         reg_rdata_o <= next_rdata;
         tin_q <= tin_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   property p_wrap;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (tick && ctrl.enable && count == COUNT_ALL_ONES && !at_reload && !wr_count)
         |=> (count == DATA_ZERO);
   endproperty
   a_wrap: assert property (p_wrap) else $error("count did not wrap to zero"); // [RULE_01]

   property p_presc_div2;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (presc_tick && ctrl.prescale == 3'h1 && !reg_wr_i) ##1 !reg_wr_i
         |-> !presc_tick ##1 presc_tick;
   endproperty
   a_presc_div2: assert property (p_presc_div2) else $error("prescale by two broken"); // [RULE_02]

   property p_cnt_edge;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (ctrl.enable && ctrl.mode == MODE_COUNTER && sel_edge && !at_reload && !wr_count)
         |=> (count == $past(count_inc));
   endproperty
   a_cnt_edge: assert property (p_cnt_edge) else $error("edge not counted"); // [RULE_03]

   property p_init_level;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !ctrl.enable |=> (tout_o == $past(ctrl.output_polarity_select));
   endproperty
   a_init_level: assert property (p_init_level) else $error("idle output level wrong"); // [RULE_04]

   property p_reload_one;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (tick && at_reload && !wr_count) |=> (count == COUNT_RESTART) && irq_o;
   endproperty
   a_reload_one: assert property (p_reload_one) else $error("reload did not restart"); // [RULE_09]

   property p_pwm_match;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (ctrl.enable && ctrl.mode == MODE_PWM && tick && !at_reload && count == match
         && !reg_wr_i) |=> (tout_o == !$past(ctrl.output_polarity_select));
   endproperty
   a_pwm_match: assert property (p_pwm_match) else $error("no toggle at match"); // [RULE_08]

   property p_pwm_return;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (ctrl.enable && ctrl.mode == MODE_PWM && tick && at_reload)
         |=> (tout_o == $past(ctrl.output_polarity_select)) && irq_o;
   endproperty
   a_pwm_return: assert property (p_pwm_return) else $error("output not restored"); // [RULE_10]

   property p_capture;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (ctrl.enable && ctrl.mode == MODE_CAPTURE && sel_edge)
         |=> (match == $past(count)) && irq_o;
   endproperty
   a_capture: assert property (p_capture) else $error("capture missed"); // [RULE_19]

   property p_cnt_out;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (ctrl.enable && ctrl.out_en && ctrl.mode == MODE_COUNTER && tick && at_reload)
         |=> (tout_o != $past(tout_o));
   endproperty
   a_cnt_out: assert property (p_cnt_out) else $error("counter output not toggled"); // [RULE_21]

endmodule
`default_nettype wire

// ==== verification/tcp_pin_model.sv ====
// Purpose: Model of the pin source that feeds the timer input.
// Assumes: Each step request flips the pin at the next clock edge.
// Notes: The pin rests low after reset and is always driven.
`timescale 1ns/1ps
`default_nettype none
module tcp_pin_model (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic step_i,
   output var logic tin_o
);
   // The pin is routed and idle before the timer gets enabled.
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         tin_o <= 1'b0;
      end else if (step_i) begin
         tin_o <= ~tin_o;
      end
   end
endmodule
`default_nettype wire

// ==== verification/tcp_timer_tb.sv ====
// Purpose: Self-checking bench of the timer in counter, PWM and capture modes.
// Assumes: The pin model drives the timer input.
// Notes: Random values come from an LFSR that starts at 96.
`timescale 1ns/1ps
`default_nettype none
module tcp_timer_tb
   import tcp_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic step = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic tin, tout, oe, irq;
   logic tin_q = 1'b0;
   logic cap_pol = 1'b0;
   int cyc = 0;
   int cap_cyc = 0;
   int irq_cnt = 0;
   int fail_count = 0;
   int n_checks = 0;
   logic [15:0] seed = 16'h0060;

   tcp_timer dut (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .tin_i(tin), .tout_o(tout),
      .tout_oe_o(oe), .irq_o(irq));
   tcp_pin_model pin (.core_clk_i(clk), .rst_n_i(rst_n), .step_i(step), .tin_o(tin));

   initial begin
      forever #4 clk = ~clk;
   end

   // Stamps the cycle of each capturing pin edge and counts interrupt pulses.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      tin_q <= tin;
      if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
      if (tin !== tin_q && tin === !cap_pol) cap_cyc <= cyc;
   end

   //////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction

   function automatic logic [15:0] ctrl(input logic en, o, pol, input logic [1:0] md,
         input logic [2:0] ps);
      return {8'h00, en, o, pol, md, ps};
   endfunction

   function automatic logic [15:0] exp_high(input logic pol, input logic [2:0] ps,
         input logic [15:0] m, r);
      return pol ? (m << ps) : ((r - m) << ps);
   endfunction

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [15:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   // Each unit is a full pulse of the pin: one rising and one falling change.
   task automatic edges(input int k);
      repeat (2 * k) begin
         @(posedge clk);
         step <= 1'b1;
         @(posedge clk);
         step <= 1'b0;
      end
      repeat (3) @(posedge clk);
   endtask

   // Counts cycles up to the next interrupt and the high cycles of the output before it.
   task automatic wait_irq(output int n, h);
      n = 0;
      h = 0;
      do begin
         @(negedge clk);
         n++;
         if (irq !== 1'b1) h += int'(tout);
      end while (irq !== 1'b1 && n < 20000);
      if (irq !== 1'b1) begin
         fail_count++;
         stop_test();
      end
   endtask

   task automatic pwm(input logic pol, input logic [2:0] ps, input logic [15:0] s, m, r,
         output int lat);
      int n, h, h0;
      wr_reg(REG_CTRL, ctrl(1'b0, 1'b1, pol, MODE_PWM, ps));
      repeat (2) @(negedge clk);
      check("idle level", 16'(tout), 16'(pol));
      wr_reg(REG_COUNT, s);
      wr_reg(REG_MATCH, m);
      wr_reg(REG_RELOAD, r);
      wr_reg(REG_CTRL, ctrl(1'b1, 1'b1, pol, MODE_PWM, ps));
      wait_irq(lat, h);
      h0 = int'(tout);
      wait_irq(n, h);
      check("period", 16'(n), r << ps);
      check("high time", 16'(h + h0), exp_high(pol, ps, m, r));
      check("pin enable", 16'(oe), 16'h0001);
      $display("pwm test done");
   endtask

   task automatic ctr(input logic pol, input logic [15:0] s, r);
      logic [15:0] v;
      int q;
      wr_reg(REG_CTRL, ctrl(1'b0, 1'b1, pol, MODE_COUNTER, 3'h0));
      repeat (2) @(negedge clk);
      check("initial level", 16'(tout), 16'(pol));
      wr_reg(REG_COUNT, s);
      wr_reg(REG_RELOAD, r);
      wr_reg(REG_CTRL, ctrl(1'b1, 1'b1, pol, MODE_COUNTER, 3'h0));
      q = irq_cnt;
      edges(int'(r - s));
      rd_reg(REG_COUNT, v);
      check("edge count", v, r);
      edges(1);
      check("reload irq", 16'(irq_cnt - q), 16'h0001);
      check("toggled out", 16'(tout), 16'(!pol));
      edges(2);
      rd_reg(REG_COUNT, v);
      check("restart count", v, 16'h0003);
      wr_reg(REG_COUNT, COUNT_ALL_ONES);
      edges(1);
      rd_reg(REG_COUNT, v);
      check("wrap", v, DATA_ZERO);
      $display("counter test done");
   endtask

   task automatic cap(input logic pol, output logic [15:0] off);
      logic [15:0] v1, v2;
      int t0, t1, q;
      cap_pol = pol;
      wr_reg(REG_CTRL, ctrl(1'b0, 1'b0, pol, MODE_CAPTURE, 3'h0));
      wr_reg(REG_RELOAD, 16'hff00);
      wr_reg(REG_COUNT, COUNT_RST);
      wr_reg(REG_CTRL, ctrl(1'b1, 1'b0, pol, MODE_CAPTURE, 3'h0));
      t0 = cyc;
      q = irq_cnt;
      edges(1);
      t1 = cap_cyc;
      rd_reg(REG_MATCH, v1);
      check("pin off", 16'(oe), 16'h0000);
      repeat (rnd() & 16'h000f) @(posedge clk);
      edges(1);
      rd_reg(REG_MATCH, v2);
      check("capture gap", v2 - v1, 16'(cap_cyc - t1));
      check("capture irq", 16'(irq_cnt - q), 16'h0002);
      off = v1 - 16'(t1 - t0);
      $display("capture test done");
   endtask

   //////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] v, m, r, s, o0, o1;
      int l1, l2;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      wr_reg(REG_STATUS, 16'hffff);
      wr_reg(3'h5, 16'hffff);
      for (int a = 0; a < 6; a++) begin
         rd_reg(3'(a), v);
         check("reset value", v, a == 1 ? COUNT_RST : DATA_ZERO);
      end
      check("reset out", 16'({tout, oe}), 16'h0000);
      $display("register test done");
      for (int p = 0; p < 2; p++) begin
         s = 16'h0001 + (rnd() & 16'h0007);
         ctr(p[0], s, s + 16'h0002 + (rnd() & 16'h0007));
      end
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 3; k++) begin
            m = 16'h0002 + (rnd() & 16'h0007);
            r = m + 16'h0001 + (rnd() & 16'h0007);
            pwm(p[0], k == 2 ? 3'h7 : 3'(k), COUNT_RST, m, r, l1);
         end
      end
      pwm(1'b0, 3'h0, COUNT_RST, 16'h0005, 16'h000c, l1);
      s = 16'h0002 + (rnd() & 16'h0007);
      pwm(1'b0, 3'h0, s, 16'h0005, 16'h000c, l2);
      check("first period", 16'(l1 - l2), s - 16'h0001);
      cap(1'b0, o0);
      cap(1'b1, o1);
      check("capture edge", o1, o0);
      stop_test();
   end
endmodule
`default_nettype wire
